// >>> core/wdt_consts.svh
/*
  Offsets, field positions, reset values and counts of the watchdog.
  Assumes inclusion by bare name from the watchdog design files.
*/
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

`define WDT_IDX_CONTROL 10'h0AA
`define WDT_IDX_CONFIG 10'h0B0
`define WDT_IDX_STATUS 10'h0B1
`define WDT_IDX_MASK 10'h0B2
`define WDT_ADDR_CONTROL {`WDT_IDX_CONTROL, 2'b00}
`define WDT_ADDR_CONFIG {`WDT_IDX_CONFIG, 2'b00}
`define WDT_ADDR_STATUS {`WDT_IDX_STATUS, 2'b00}
`define WDT_ADDR_MASK {`WDT_IDX_MASK, 2'b00}

`define WDT_BIT_ENABLE 7
`define WDT_BIT_CLEAR 6
`define WDT_BIT_SLEEP 4
`define WDT_BIT_FLAG 3
`define WDT_PS_HI 2
`define WDT_PS_LO 0
`define WDT_BIT_BOOT_DISABLE 7

`define WDT_CONFIG_RESET 8'hFF
`define WDT_EV_TIMEOUT 0
`define WDT_EV_REFUSED 1
`define WDT_EV_WIDTH 2

`define WDT_RC_FREQ_HZ 10000
`define WDT_TIMEOUT_TICKS 64
`define WDT_DIV_WIDTH 8

`endif

// >>> core/wdt_pkg.sv
/*
  Types shared by the watchdog design.
  Assumes the constants header is compiled alongside.
*/
package wdt_pkg;
  typedef logic [2:0] wdt_presc_t;
  typedef enum logic [2:0] {
    wdt_div_1, wdt_div_2, wdt_div_8, wdt_div_16,
    wdt_div_32, wdt_div_64, wdt_div_128, wdt_div_256
  } wdt_div_sel_t;
endpackage

// >>> core/wdt_watchdog.sv
/*
  Watchdog reset timer with an APB register slave.
  Assumes one 100 MHz clock, the RC oscillator arriving as a plain
  asynchronous pin, and the timed-access unlock decided elsewhere.
*/
// What this block does
// - Time-out fires a system reset one pclk later
// - Clear strobe zeroes count, then clears itself
// - Enable bit 7 stops or runs counter
// - Prescale field picks RC clock divider
// - Time-out after 64 prescaled RC ticks
// - Watchdog reset sets reset flag bit 3
// - Flag cleared only by power-on or software
// - Run-in-sleep bit 4 gates counting in sleep
// - Count cleared entering and leaving sleep
// - Every reset loads enable from boot bit inverted
// - Boot bit one disables, zero enables watchdog
// - Sleep bit, prescale cleared only at power-on
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_watchdog #(
  parameter int TIMEOUT_TICKS = `WDT_TIMEOUT_TICKS,
  parameter int ADDR_WIDTH = 12
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Surroundings
  input wire logic rc_clk_pin,
  input wire logic timed_access_unlock,
  input wire logic other_reset,
  input wire logic cpu_idle,
  input wire logic cpu_power_down,
  // Results
  output logic dog_reset,
  output logic irq
);

  // Count width; the tick count need not be a power of two
  localparam int CW = $clog2(TIMEOUT_TICKS);

  // Refuse sizes the counters and the address decode cannot serve
  if (TIMEOUT_TICKS < 2 || ADDR_WIDTH < 12) begin : g_bad_params
    $error("wdt_watchdog: unsupported parameter values");
  end

  // Divider end value for each prescale choice
  function automatic logic [`WDT_DIV_WIDTH-1:0] div_last(
    input wdt_pkg::wdt_presc_t sel
  );
    case (wdt_pkg::wdt_div_sel_t'(sel))
      wdt_pkg::wdt_div_1: div_last = 8'h00;
      wdt_pkg::wdt_div_2: div_last = 8'h01;
      wdt_pkg::wdt_div_8: div_last = 8'h07;
      wdt_pkg::wdt_div_16: div_last = 8'h0F;
      wdt_pkg::wdt_div_32: div_last = 8'h1F;
      wdt_pkg::wdt_div_64: div_last = 8'h3F;
      wdt_pkg::wdt_div_128: div_last = 8'h7F;
      default: div_last = 8'hFF;
    endcase
  endfunction

  // State
  logic rc_s1, rc_s2, rc_s3, rc_level;
  logic dog_enable, run_in_sleep, dog_reset_flag;
  wdt_pkg::wdt_presc_t prescale_select;
  logic [7:0] boot_config_byte;
  logic [`WDT_DIV_WIDTH-1:0] div_count;
  logic [CW-1:0] dog_count;
  logic sleeping;
  logic [`WDT_EV_WIDTH-1:0] status, mask;
  logic [31:0] rdata_q;
  logic err_q;

  // Next values
  logic next_rc_level, next_dog_enable, next_run_in_sleep;
  logic next_dog_reset_flag, next_dog_reset, next_sleeping;
  wdt_pkg::wdt_presc_t next_prescale_select;
  logic [7:0] next_boot_config_byte;
  logic [`WDT_DIV_WIDTH-1:0] next_div_count;
  logic [CW-1:0] next_dog_count;
  logic [`WDT_EV_WIDTH-1:0] next_status, next_mask;
  logic [31:0] next_rdata_q;
  logic next_err_q;

  // Decode
  logic setup, access, wr, rd, rc_tick, counting, timeout;
  logic hit_ctl, hit_cfg, hit_sts, hit_msk, mapped, sleep_now;
  logic ctl_write, refused, clear_req;
  // Events: bit 0 time-out, bit 1 refused control write
  logic [`WDT_EV_WIDTH-1:0] events;
  logic [ADDR_WIDTH-1:0] a_ctl, a_cfg, a_sts, a_msk;

  assign a_ctl = ADDR_WIDTH'(`WDT_ADDR_CONTROL);
  assign a_cfg = ADDR_WIDTH'(`WDT_ADDR_CONFIG);
  assign a_sts = ADDR_WIDTH'(`WDT_ADDR_STATUS);
  assign a_msk = ADDR_WIDTH'(`WDT_ADDR_MASK);

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign hit_ctl = paddr == a_ctl;
  assign hit_cfg = paddr == a_cfg;
  assign hit_sts = paddr == a_sts;
  assign hit_msk = paddr == a_msk;
  // Anything else answers with an error and reads zero
  assign mapped = hit_ctl | hit_cfg | hit_sts | hit_msk;

  // Zero wait states; read data was captured during setup
  assign pready = access;
  assign prdata = rdata_q;
  assign pslverr = access & err_q;

  // Unlocked writes only reach the protected control register
  assign ctl_write = wr & hit_ctl & timed_access_unlock;
  // A refused write still leaves an event that software can see
  assign refused = wr & hit_ctl & ~timed_access_unlock;
  assign clear_req = ctl_write & pwdata[`WDT_BIT_CLEAR];

  // RC tick: a rise counts once the second and third stages agree
  assign rc_tick = rc_s2 & rc_s3 & ~rc_level;
  // A move from idle straight to power-down is not a sleep edge
  assign sleep_now = cpu_idle | cpu_power_down;
  assign counting = dog_enable
    & (~sleep_now | run_in_sleep);
  // Time-out on the last divider step of the last count
  assign timeout = counting & rc_tick
    & (div_count == div_last(prescale_select))
    & (dog_count == CW'(TIMEOUT_TICKS - 1));

  always_comb begin
    events = '0;
    events[`WDT_EV_TIMEOUT] = timeout;
    events[`WDT_EV_REFUSED] = refused;
  end

  always_comb begin
    next_rc_level = (rc_s2 == rc_s3) ? rc_s3 : rc_level;
    next_sleeping = sleep_now;
    // Registered so the system reset is one clean cycle
    next_dog_reset = timeout;
    next_dog_enable = dog_enable;
    next_run_in_sleep = run_in_sleep;
    next_prescale_select = prescale_select;
    next_dog_reset_flag = dog_reset_flag;
    next_boot_config_byte = boot_config_byte;
    next_div_count = div_count;
    next_dog_count = dog_count;
    next_mask = mask;
    next_status = status;

    // Counting
    if (counting && rc_tick) begin
      if (div_count == div_last(prescale_select)) begin
        next_div_count = '0;
        next_dog_count = dog_count + CW'(1);
      end else begin
        next_div_count = div_count + 8'h01;
      end
    end

    // Register writes
    if (ctl_write) begin
      next_dog_enable = pwdata[`WDT_BIT_ENABLE];
      next_run_in_sleep = pwdata[`WDT_BIT_SLEEP];
      next_prescale_select =
        pwdata[`WDT_PS_HI:`WDT_PS_LO];
      // Software may only clear the flag
      next_dog_reset_flag = dog_reset_flag
        & pwdata[`WDT_BIT_FLAG];
    end
    // Config needs no unlock; it stands in for programming the part
    if (wr && hit_cfg) begin
      next_boot_config_byte = pwdata[7:0];
    end
    if (wr && hit_msk) begin
      next_mask = pwdata[`WDT_EV_WIDTH-1:0];
    end

    // Status: read clears, a new event in the same cycle wins
    if (rd && hit_sts) begin
      next_status = '0;
    end
    next_status = next_status | events;

    // Strobe and sleep edges restart from a known count
    if (clear_req || (sleep_now != sleeping)) begin
      next_div_count = '0;
      next_dog_count = '0;
    end

    // Watchdog or other reset; set of the flag beats a clear
    if (timeout || other_reset) begin
      next_dog_enable =
        ~boot_config_byte[`WDT_BIT_BOOT_DISABLE];
      // Counts restart so the reloaded state gets a full interval
      next_div_count = '0;
      next_dog_count = '0;
      // Sleep and prescale survive non power-on resets
      next_run_in_sleep = run_in_sleep;
      next_prescale_select = prescale_select;
      next_dog_reset_flag = dog_reset_flag;
    end
    if (timeout) begin
      next_dog_reset_flag = 1'b1;
    end
  end

  // Read data and error captured in the setup cycle
  always_comb begin
    next_rdata_q = rdata_q;
    next_err_q = err_q;
    if (setup) begin
      next_rdata_q = '0;
      next_err_q = ~mapped;
      if (hit_ctl) begin
        // Strobe bit and reserved bit read zero
        next_rdata_q[`WDT_BIT_ENABLE] = dog_enable;
        next_rdata_q[`WDT_BIT_SLEEP] = run_in_sleep;
        next_rdata_q[`WDT_BIT_FLAG] = dog_reset_flag;
        next_rdata_q[`WDT_PS_HI:`WDT_PS_LO] = prescale_select;
      end
      if (hit_cfg) begin
        next_rdata_q[7:0] = boot_config_byte;
      end
      if (hit_sts) begin
        next_rdata_q[`WDT_EV_WIDTH-1:0] = status;
      end
      if (hit_msk) begin
        next_rdata_q[`WDT_EV_WIDTH-1:0] = mask;
      end
    end
  end

  // Only the second stage reads the first, which may be metastable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_s3 <= 1'b0;
    end else begin
      rc_s1 <= rc_clk_pin;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
    end
  end

  // Power-on reset: config unprogrammed, so the watchdog starts off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_level <= 1'b0;
      sleeping <= 1'b0;
      dog_reset <= 1'b0;
      dog_enable <= 1'b0;
      run_in_sleep <= 1'b0;
      prescale_select <= '0;
      dog_reset_flag <= 1'b0;
      boot_config_byte <= `WDT_CONFIG_RESET;
      div_count <= '0;
      dog_count <= '0;
      status <= '0;
      mask <= '0;
    end else begin
      rc_level <= next_rc_level;
      sleeping <= next_sleeping;
      dog_reset <= next_dog_reset;
      dog_enable <= next_dog_enable;
      run_in_sleep <= next_run_in_sleep;
      prescale_select <= next_prescale_select;
      dog_reset_flag <= next_dog_reset_flag;
      boot_config_byte <= next_boot_config_byte;
      div_count <= next_div_count;
      dog_count <= next_dog_count;
      status <= next_status;
      mask <= next_mask;
    end
  end

  // Readback is registered so prdata never glitches in the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= next_rdata_q;
      err_q <= next_err_q;
    end
  end

  // Level interrupt; held until the status read clears the event
  assign irq = |(status & mask);

endmodule

// >>> test/wdt_properties.sv
/* Port assertions of the watchdog.
   Bound to every wdt_watchdog instance. */
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_properties #(parameter int ADDR_WIDTH = 12) (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Watchdog
  input wire logic rc_clk_pin,
  input wire logic dog_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] since_rc;
  wire acc = psel && penable;
  wire rdc = acc && !pwrite && paddr == `WDT_ADDR_CONTROL;
  // Age of the last rc edge; saturates so it never wraps to look fresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_rc <= 8'hFF;
    else if ($rose(rc_clk_pin)) since_rc <= 8'h00;
    else if (since_rc != 8'hFF) since_rc <= since_rc + 8'h01;
  end
  a_ready_access: assert property (acc |-> pready)
    else $error("no ready in access");
  a_ready_idle: assert property (!acc |-> !pready)
    else $error("ready outside access");
  a_pulse_single: assert property (dog_reset |=> !dog_reset)
    else $error("reset pulse too long");
  a_reset_fresh: assert property (dog_reset |-> since_rc < 8'h0C)
    else $error("reset without rc edge");
  a_strobe_zero: assert property (rdc |-> prdata[6:5] == 2'h0)
    else $error("strobe reads set");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  a_low_unmapped: assert property (acc && paddr < 12'h200 |-> pslverr)
    else $error("unmapped without error");
  a_ctl_ok: assert property (rdc |-> !pslverr)
    else $error("control read error");
  c_reset: cover property (dog_reset);
  c_error: cover property (acc && pslverr);
  c_flag: cover property (rdc && prdata[3]);
endmodule
bind wdt_watchdog wdt_properties #(.ADDR_WIDTH(ADDR_WIDTH)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rc_clk_pin(rc_clk_pin), .dog_reset(dog_reset));

// >>> test/watchdog_reset_timer_test.sv
/* Self-checking bench of the watchdog.
   Assumes the design files are compiled first. */
`timescale 1ns/1ps
`include "wdt_consts.svh"
`define CHK(n, x, g) tests_run++; if ((g) !== (x)) begin \
  $display("wrong value %s exp %h got %h", n, x, g); err_count++; end
module watchdog_reset_timer_test;
  localparam logic [11:0] CT = `WDT_ADDR_CONTROL;
  localparam logic [11:0] CF = `WDT_ADDR_CONFIG;
  localparam logic [11:0] ST = `WDT_ADDR_STATUS;
  localparam logic [11:0] MK = `WDT_ADDR_MASK;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d, x;} wdt_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, dog_reset, irq, e;
  logic rc = 0, ul = 0, orst = 0, idle = 0, pd = 0;
  int err_count = 0, tests_run = 0, pulses = 0, p;
  int divs[8] = '{1, 2, 8, 16, 32, 64, 128, 256};
  wdt_row_t rows[6] = '{'{1'h0, CT, 32'h0, 32'h0},
    '{1'h0, CF, 32'h0, 32'hFF}, '{1'h0, ST, 32'h0, 32'h0},
    '{1'h1, MK, 32'h3, 32'h0}, '{1'h0, MK, 32'h0, 32'h3},
    '{1'h1, MK, 32'h0, 32'h0}};
  wdt_watchdog #(.TIMEOUT_TICKS(4)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_clk_pin(rc), .timed_access_unlock(ul), .other_reset(orst),
    .cpu_idle(idle), .cpu_power_down(pd), .dog_reset(dog_reset),
    .irq(irq));
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) if (dog_reset === 1'b1) pulses <= pulses + 1;
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Whole run is about 17k cycles
  initial begin
    #400000;
    err_count++;
    summarize();
  end
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK("read", x, r)
  endtask
  task automatic wc(input logic [7:0] d);
    ul <= 1'b1;
    apb(1'b1, CT, {24'h0, d});
    ul <= 1'b0;
  endtask
  // Slow rc edges, several pclk apart as a real oscillator would be
  task automatic tick(input int n);
    repeat (n) begin
      rc <= 1'b1;
      repeat (4) @(posedge pclk);
      rc <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) begin
        `CHK("row", rows[i].x, r)
      end
    end
    apb(1'b0, 12'h004, 32'h0);
    `CHK("unmapped", 1'b1, e)
    apb(1'b1, CT, 32'h97);
    rd(CT, 32'h0);
    rd(ST, 32'h2);
    $display("registers done");
    for (int s = 0; s < 8; s++) begin
      p = pulses;
      wc(8'hC0 | 8'(s));
      tick(4 * divs[s] - 1);
      `CHK("early", p, pulses)
      tick(1);
      `CHK("fire", p + 1, pulses)
      rd(CT, 32'h08 | s);
    end
    `CHK("irq", 1'b0, irq)
    apb(1'b1, MK, 32'h1);
    @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    rd(ST, 32'h1);
    @(posedge pclk);
    `CHK("irq", 1'b0, irq)
    $display("prescale done");
    p = pulses;
    wc(8'hC0);
    tick(3);
    wc(8'hC0);
    tick(3);
    `CHK("clear", p, pulses)
    tick(1);
    `CHK("fire", p + 1, pulses)
    wc(8'hC0);
    idle <= 1'b1;
    tick(6);
    `CHK("halt", p + 1, pulses)
    idle <= 1'b0;
    wc(8'hD0);
    tick(3);
    pd <= 1'b1;
    tick(3);
    `CHK("entry", p + 1, pulses)
    tick(1);
    `CHK("sleep", p + 2, pulses)
    wc(8'hD0);
    tick(3);
    pd <= 1'b0;
    tick(3);
    `CHK("wake", p + 2, pulses)
    tick(1);
    `CHK("fire", p + 3, pulses)
    apb(1'b1, CF, 32'h7F);
    orst <= 1'b1;
    @(posedge pclk);
    orst <= 1'b0;
    @(posedge pclk);
    rd(CT, 32'h98);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CT, 32'h0);
    rd(CF, 32'hFF);
    $display("resets done");
    summarize();
  end
endmodule
